/* File: design/ttc_params.svh */
`ifndef TTC_PARAMS_SVH
`define TTC_PARAMS_SVH
// Depth of every input and output register chain
`define TTC_SYNC_STAGES 3
// Mode indicator encodings
`define TTC_MODE_TEN_LANE 1'b0
`define TTC_MODE_FOUR_LANE 1'b1
// Default packet count per sanity run
`define TTC_PKT_COUNT 16'h0010
// Default payload word count per packet
`define TTC_PKT_WORDS 8'h04
// Default configuration write count for a mode switch
`define TTC_CFG_WRITES 8'h0a
// Default statistics read burst length
`define TTC_STATS_READS 8'h08
// Seed for the payload pattern
`define TTC_SEED 32'h0000_0001
// FIFO depth
`define TTC_FIFO_DEPTH 8
`endif

/* File: design/ttc_pkg.sv */
`default_nettype none
package ttc_pkg;
	// Packed user inputs after the register chain
	typedef struct packed {
		logic restart;
		logic mode_switch;
		logic simplex_aligned;
		logic stats_tick;
	} ttc_user_in_t;
	// Status flags before the output chain
	typedef struct packed {
		logic tx_lock;
		logic rx_lock;
		logic rx_aligned;
		logic tx_busy;
		logic rx_busy;
		logic tx_done;
		logic rx_done;
		logic data_fail;
		logic lane_mode;
	} ttc_status_t;
	typedef enum logic [2:0] {
		TTC_G_WAIT,
		TTC_G_SEND,
		TTC_G_DONE
	} ttc_gen_st_t;
	typedef enum logic [2:0] {
		TTC_M_WAIT,
		TTC_M_RECV,
		TTC_M_DONE
	} ttc_mon_st_t;
	typedef enum logic [1:0] {
		TTC_C_IDLE,
		TTC_C_WRITE,
		TTC_C_DONE
	} ttc_cfg_st_t;
endpackage
`default_nettype wire

/* File: design/ttc_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module ttc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic [WIDTH-1:0] dout_r, dout_nxt;
	logic ov_r, ov_nxt;
	logic wr, rd;

	// Output register counts as one slot beyond the array
	always_comb
	begin
		rd = (cnt_r != '0) && (!ov_r || out_ready_i);
		wr = in_valid_i && in_ready_o;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		dout_nxt = dout_r;
		ov_nxt = ov_r;
		if (ov_r && out_ready_i)
			ov_nxt = 1'b0;
		if (rd)
		begin
			dout_nxt = mem_r[rp_r];
			ov_nxt = 1'b1;
			rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
		end
		if (wr)
			wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
		cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
		if (flush_i)
		begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
			ov_nxt = 1'b0;
		end
	end

	assign in_ready_o = (cnt_r != (AW+1)'(DEPTH)) && !flush_i;
	assign out_valid_o = ov_r;
	assign out_data_o = dout_r;

	// Storage has no reset; pointers, count and output register do
	always_ff @(posedge mclk_i)
	begin
		if (wr)
			mem_r[wp_r] <= in_data_i;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			dout_r <= '0;
			ov_r <= 1'b0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			dout_r <= dout_nxt;
			ov_r <= ov_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: design/ttc_top.sv */
// What this block does
// - All user inputs and status outputs pass three registers inside.
// - Simplex transmit build: generator waits for external receive-aligned input.
// - Mode-switch pulse starts a configuration write sequence toggling lane mode.
// - After the configuration writes, the sanity test reruns in the new mode.
// - Restart reruns generator and monitor, accepted only while both idle.
// - Generator busy is high while generator is occupied, low when idle.
// - Monitor busy is high while monitor is occupied, low when idle.
// - Transmit done asserts after all programmed packets are written into the FIFO.
// - Receive done asserts after all expected packets are received.
// - Data fail asserts when received payload mismatches expected pattern.
// - Lane-mode indicator: 0 for ten-lane, 1 for four-lane mode.
// - Lock outputs follow transceiver lock; transmit lock only in simplex build.
// - Receive-aligned output follows core alignment report.
// - Statistics tick triggers periodic statistics reads when register access built.
// - Configuration completion raises a done pulse that resets the transceiver.
`timescale 1ns/10ps
`default_nettype none
`include "ttc_params.svh"
module ttc_top #(
	parameter bit SIMPLEX_TX = 1'b0,
	parameter bit SWITCHABLE = 1'b1,
	parameter bit STATS_IF = 1'b1,
	parameter logic [15:0] PKT_COUNT = `TTC_PKT_COUNT,
	parameter logic [7:0] PKT_WORDS = `TTC_PKT_WORDS,
	parameter logic [7:0] CFG_WRITES = `TTC_CFG_WRITES,
	parameter logic [7:0] STATS_READS = `TTC_STATS_READS
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic restart_i,
	input wire logic mode_switch_i,
	input wire logic simplex_aligned_i,
	input wire logic stats_snapshot_tick_i,
	input wire logic serdes_tx_lock_i,
	input wire logic serdes_rx_lock_i,
	input wire logic core_rx_aligned_i,
	output logic tx_valid_o,
	output logic [31:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic rx_valid_i,
	input wire logic [31:0] rx_data_i,
	output logic cfg_wr_o,
	input wire logic cfg_ack_i,
	output logic reconfig_write_complete_o,
	output logic serdes_reset_o,
	output logic stats_rd_o,
	output logic transmit_serdes_lock_ind_o,
	output logic receive_serdes_lock_ind_o,
	output logic rx_aligned_o,
	output logic tx_busy_o,
	output logic rx_busy_o,
	output logic tx_done_o,
	output logic rx_done_o,
	output logic rx_data_fail_o,
	output logic lane_mode_o
);
	localparam int NS = `TTC_SYNC_STAGES;
	localparam int NI = $bits(ttc_pkg::ttc_user_in_t) + 3;
	localparam int NO = $bits(ttc_pkg::ttc_status_t);

	logic [NS-1:0] in_chain_r [NI];
	logic [NS-1:0] out_chain_r [NO];
	logic [NI-1:0] in_raw;
	ttc_pkg::ttc_user_in_t uin;
	logic s_tx_lock, s_rx_lock, s_aligned;
	ttc_pkg::ttc_status_t st;
	logic [NO-1:0] st_q;

	assign in_raw = {restart_i, mode_switch_i, simplex_aligned_i, stats_snapshot_tick_i,
		serdes_tx_lock_i, serdes_rx_lock_i, core_rx_aligned_i};
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			for (int i = 0; i < NI; i++)
				in_chain_r[i] <= '0;
			for (int i = 0; i < NO; i++)
				out_chain_r[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NI; i++)
				in_chain_r[i] <= {in_chain_r[i][NS-2:0], in_raw[i]};
			for (int i = 0; i < NO; i++)
				out_chain_r[i] <= {out_chain_r[i][NS-2:0], st[i]};
		end
	end
	// Only the last stage is read; earlier stages may be metastable
	always_comb
	begin
		uin.restart = in_chain_r[6][NS-1];
		uin.mode_switch = in_chain_r[5][NS-1];
		uin.simplex_aligned = in_chain_r[4][NS-1];
		uin.stats_tick = in_chain_r[3][NS-1];
		s_tx_lock = in_chain_r[2][NS-1];
		s_rx_lock = in_chain_r[1][NS-1];
		s_aligned = in_chain_r[0][NS-1];
		for (int i = 0; i < NO; i++)
			st_q[i] = out_chain_r[i][NS-1];
	end

	// Edge detect state
	logic rst_d_r, sw_d_r, tk_d_r;
	logic restart_p, switch_p, tick_p;
	ttc_pkg::ttc_gen_st_t g_r, g_nxt;
	ttc_pkg::ttc_mon_st_t m_r, m_nxt;
	ttc_pkg::ttc_cfg_st_t c_r, c_nxt;
	logic [15:0] gpk_r, gpk_nxt, mpk_r, mpk_nxt;
	logic [7:0] gw_r, gw_nxt, mw_r, mw_nxt;
	logic [31:0] gpat_r, gpat_nxt, mpat_r, mpat_nxt;
	logic fail_r, fail_nxt, mode_r, mode_nxt;
	logic [7:0] cw_r, cw_nxt, sr_r, sr_nxt;
	logic cwr_r, cwr_nxt, cdone_r, cdone_nxt, srd_r, srd_nxt;
	logic link_up, gen_go, rerun;
	logic f_in_valid, f_in_ready, f_out_valid;
	logic [31:0] f_out_data;

	assign restart_p = uin.restart && !rst_d_r;
	assign switch_p = uin.mode_switch && !sw_d_r;
	assign tick_p = uin.stats_tick && !tk_d_r;
	// Transmit lock only counts in simplex build
	assign link_up = s_rx_lock && s_aligned && (!SIMPLEX_TX || s_tx_lock);
	// Simplex generator waits for remote alignment
	assign gen_go = SIMPLEX_TX ? (s_tx_lock && uin.simplex_aligned) : link_up;
	// Restart only while both busy low
	assign rerun = (restart_p && g_r == ttc_pkg::TTC_G_DONE && m_r == ttc_pkg::TTC_M_DONE)
		|| cdone_r;

	// Generator: pattern words into the FIFO
	always_comb
	begin
		g_nxt = g_r;
		gpk_nxt = gpk_r;
		gw_nxt = gw_r;
		gpat_nxt = gpat_r;
		f_in_valid = 1'b0;
		case (g_r)
			ttc_pkg::TTC_G_WAIT:
				if (gen_go && c_r == ttc_pkg::TTC_C_IDLE)
					g_nxt = ttc_pkg::TTC_G_SEND;
			ttc_pkg::TTC_G_SEND:
			begin
				f_in_valid = 1'b1;
				// FIFO full stalls the generator
				if (f_in_ready)
				begin
					gpat_nxt = gpat_r + 32'h0000_0001;
					gw_nxt = gw_r + 8'h01;
					if (gw_r == PKT_WORDS - 8'h01)
					begin
						gw_nxt = '0;
						gpk_nxt = gpk_r + 16'h0001;
						if (gpk_r == PKT_COUNT - 16'h0001)
							g_nxt = ttc_pkg::TTC_G_DONE;
					end
				end
			end
			default:
				g_nxt = ttc_pkg::TTC_G_DONE;
		endcase
		if (rerun)
		begin
			g_nxt = ttc_pkg::TTC_G_WAIT;
			gpk_nxt = '0;
			gw_nxt = '0;
			gpat_nxt = `TTC_SEED;
		end
	end

	ttc_fifo #(
		.WIDTH(32),
		.DEPTH(`TTC_FIFO_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.flush_i(rerun),
		.in_valid_i(f_in_valid),
		.in_ready_o(f_in_ready),
		.in_data_i(gpat_r),
		.out_valid_o(f_out_valid),
		.out_ready_i(tx_ready_i),
		.out_data_o(f_out_data)
	);

	// Monitor: compare received words with the expected pattern
	always_comb
	begin
		m_nxt = m_r;
		mpk_nxt = mpk_r;
		mw_nxt = mw_r;
		mpat_nxt = mpat_r;
		fail_nxt = fail_r;
		case (m_r)
			ttc_pkg::TTC_M_WAIT:
				if (link_up && c_r == ttc_pkg::TTC_C_IDLE)
					m_nxt = ttc_pkg::TTC_M_RECV;
			ttc_pkg::TTC_M_RECV:
				if (rx_valid_i)
				begin
					if (rx_data_i != mpat_r)
						fail_nxt = 1'b1;
					mpat_nxt = mpat_r + 32'h0000_0001;
					mw_nxt = mw_r + 8'h01;
					if (mw_r == PKT_WORDS - 8'h01)
					begin
						mw_nxt = '0;
						mpk_nxt = mpk_r + 16'h0001;
						if (mpk_r == PKT_COUNT - 16'h0001)
							m_nxt = ttc_pkg::TTC_M_DONE;
					end
				end
			default:
				m_nxt = ttc_pkg::TTC_M_DONE;
		endcase
		if (rerun)
		begin
			m_nxt = ttc_pkg::TTC_M_WAIT;
			mpk_nxt = '0;
			mw_nxt = '0;
			mpat_nxt = `TTC_SEED;
			fail_nxt = 1'b0;
		end
	end

	// Mode switch and statistics sequencing
	always_comb
	begin
		c_nxt = c_r;
		cw_nxt = cw_r;
		cwr_nxt = 1'b0;
		cdone_nxt = 1'b0;
		mode_nxt = mode_r;
		sr_nxt = sr_r;
		srd_nxt = 1'b0;
		case (c_r)
			ttc_pkg::TTC_C_IDLE:
				if (SWITCHABLE && switch_p)
				begin
					c_nxt = ttc_pkg::TTC_C_WRITE;
					cw_nxt = '0;
				end
			ttc_pkg::TTC_C_WRITE:
			begin
				cwr_nxt = !cfg_ack_i;
				if (cfg_ack_i)
				begin
					cw_nxt = cw_r + 8'h01;
					if (cw_r == CFG_WRITES - 8'h01)
						c_nxt = ttc_pkg::TTC_C_DONE;
				end
			end
			default:
			begin
				cdone_nxt = 1'b1;
				mode_nxt = !mode_r;
				c_nxt = ttc_pkg::TTC_C_IDLE;
			end
		endcase
		// Tick starts a burst of statistics reads
		if (STATS_IF && tick_p && sr_r == '0)
			sr_nxt = STATS_READS;
		else if (sr_r != '0)
		begin
			srd_nxt = 1'b1;
			sr_nxt = sr_r - 8'h01;
		end
	end

	// Status flags before the output chain
	always_comb
	begin
		st.tx_lock = SIMPLEX_TX ? s_tx_lock : 1'b0;
		st.rx_lock = s_rx_lock;
		st.rx_aligned = s_aligned;
		st.tx_busy = (g_r != ttc_pkg::TTC_G_DONE);
		st.rx_busy = (m_r != ttc_pkg::TTC_M_DONE);
		st.tx_done = (g_r == ttc_pkg::TTC_G_DONE);
		st.rx_done = (m_r == ttc_pkg::TTC_M_DONE);
		st.data_fail = fail_r;
		st.lane_mode = SWITCHABLE ? mode_r : `TTC_MODE_TEN_LANE;
	end

	// State registers; reset puts generator and monitor in wait, sequencer idle
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rst_d_r <= 1'b0;
			sw_d_r <= 1'b0;
			tk_d_r <= 1'b0;
			g_r <= ttc_pkg::TTC_G_WAIT;
			m_r <= ttc_pkg::TTC_M_WAIT;
			c_r <= ttc_pkg::TTC_C_IDLE;
			gpk_r <= '0;
			gw_r <= '0;
			gpat_r <= `TTC_SEED;
			mpk_r <= '0;
			mw_r <= '0;
			mpat_r <= `TTC_SEED;
			fail_r <= 1'b0;
			mode_r <= `TTC_MODE_TEN_LANE;
			cw_r <= '0;
			cwr_r <= 1'b0;
			cdone_r <= 1'b0;
			sr_r <= '0;
			srd_r <= 1'b0;
		end
		else
		begin
			rst_d_r <= uin.restart;
			sw_d_r <= uin.mode_switch;
			tk_d_r <= uin.stats_tick;
			g_r <= g_nxt;
			m_r <= m_nxt;
			c_r <= c_nxt;
			gpk_r <= gpk_nxt;
			gw_r <= gw_nxt;
			gpat_r <= gpat_nxt;
			mpk_r <= mpk_nxt;
			mw_r <= mw_nxt;
			mpat_r <= mpat_nxt;
			fail_r <= fail_nxt;
			mode_r <= mode_nxt;
			cw_r <= cw_nxt;
			cwr_r <= cwr_nxt;
			cdone_r <= cdone_nxt;
			sr_r <= sr_nxt;
			srd_r <= srd_nxt;
		end
	end

	// Stream and sequencer outputs are already registered
	assign tx_valid_o = f_out_valid;
	assign tx_data_o = f_out_data;
	assign cfg_wr_o = cwr_r;
	assign reconfig_write_complete_o = cdone_r;
	assign serdes_reset_o = cdone_r;
	assign stats_rd_o = srd_r;
	assign {transmit_serdes_lock_ind_o, receive_serdes_lock_ind_o, rx_aligned_o, tx_busy_o,
		rx_busy_o, tx_done_o, rx_done_o, rx_data_fail_o, lane_mode_o} = st_q;
endmodule
`default_nettype wire

/* File: verif/ttc_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module ttc_top_asserts #(
	parameter bit SIMPLEX_TX = 1'b0
) (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic core_rx_aligned_i,
	input wire logic serdes_rx_lock_i,
	input wire logic cfg_ack_i,
	input wire logic cfg_wr_o,
	input wire logic reconfig_write_complete_o,
	input wire logic serdes_reset_o,
	input wire logic stats_rd_o,
	input wire logic transmit_serdes_lock_ind_o,
	input wire logic receive_serdes_lock_ind_o,
	input wire logic rx_aligned_o,
	input wire logic tx_busy_o,
	input wire logic rx_busy_o,
	input wire logic tx_done_o,
	input wire logic rx_done_o,
	input wire logic lane_mode_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	property p_algn;
		core_rx_aligned_i [*8] |=> rx_aligned_o;
	endproperty
	a_algn: assert property (p_algn) else $error("aligned output low");
	property p_rxlk;
		!serdes_rx_lock_i [*8] |=> !receive_serdes_lock_ind_o;
	endproperty
	a_rxlk: assert property (p_rxlk) else $error("lock output high");
	property p_txlk;
		SIMPLEX_TX || !transmit_serdes_lock_ind_o;
	endproperty
	a_txlk: assert property (p_txlk) else $error("transmit lock set");
	property p_txdn;
		$rose(tx_done_o) |-> $fell(tx_busy_o);
	endproperty
	a_txdn: assert property (p_txdn) else $error("tx busy and done disagree");
	property p_rxdn;
		$rose(rx_done_o) |-> $fell(rx_busy_o);
	endproperty
	a_rxdn: assert property (p_rxdn) else $error("rx busy and done disagree");
	property p_cfgw;
		cfg_wr_o && !cfg_ack_i |=> cfg_wr_o;
	endproperty
	a_cfgw: assert property (p_cfgw) else $error("write dropped before ack");
	property p_cmpl;
		reconfig_write_complete_o |-> serdes_reset_o ##1 !reconfig_write_complete_o;
	endproperty
	a_cmpl: assert property (p_cmpl) else $error("completion pulse wrong");
	property p_mode;
		$rose(reconfig_write_complete_o) |-> ##[1:5] $changed(lane_mode_o);
	endproperty
	a_mode: assert property (p_mode) else $error("lane mode not toggled");
	property p_stat;
		$rose(stats_rd_o) |-> stats_rd_o [*8] ##1 !stats_rd_o;
	endproperty
	a_stat: assert property (p_stat) else $error("read burst length wrong");
endmodule
bind ttc_top ttc_top_asserts #(.SIMPLEX_TX(SIMPLEX_TX)) u_chk (.mclk_i(mclk_i), .rstn_i(rstn_i),
	.core_rx_aligned_i(core_rx_aligned_i), .serdes_rx_lock_i(serdes_rx_lock_i), .cfg_ack_i(cfg_ack_i),
	.cfg_wr_o(cfg_wr_o), .reconfig_write_complete_o(reconfig_write_complete_o), .serdes_reset_o(serdes_reset_o),
	.stats_rd_o(stats_rd_o), .transmit_serdes_lock_ind_o(transmit_serdes_lock_ind_o),
	.receive_serdes_lock_ind_o(receive_serdes_lock_ind_o), .rx_aligned_o(rx_aligned_o), .tx_busy_o(tx_busy_o),
	.rx_busy_o(rx_busy_o), .tx_done_o(tx_done_o), .rx_done_o(rx_done_o), .lane_mode_o(lane_mode_o));
`default_nettype wire

/* File: verif/ttc_mac_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ttc_mac_model (
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic link_i,
	input wire logic stall_i,
	input wire logic corrupt_i,
	input wire logic tx_valid_i,
	input wire logic [31:0] tx_data_i,
	input wire logic cfg_wr_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [31:0] rx_data_o,
	output logic cfg_ack_o,
	output logic lock_o
);
	// Lock and alignment follow the link
	assign tx_ready_o = !stall_i;
	assign lock_o = link_i;
	// Loopback; idle data inverted so stale words never look valid
	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_valid_o <= 1'b0;
			rx_data_o <= 32'h0;
			cfg_ack_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= tx_valid_i && !stall_i && link_i;
			rx_data_o <= (tx_valid_i && !stall_i) ? (tx_data_i ^ {31'h0, corrupt_i}) : ~rx_data_o;
			cfg_ack_o <= cfg_wr_i && !cfg_ack_o; // One ack per write, then a gap
		end
	end
endmodule
`default_nettype wire

/* File: verif/tb_ttc_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_ttc_top;
	logic mclk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic restart = 1'b0;
	logic mswitch = 1'b0;
	logic tick = 1'b0;
	logic simplex = 1'b0;
	logic link = 1'b0;
	logic stall = 1'b0;
	logic hold = 1'b0;
	logic corrupt = 1'b0;
	logic tx_valid, tx_ready, rx_valid, cfg_wr, cfg_ack, lock, rxd_q;
	logic [31:0] tx_data, rx_data;
	logic cmpl, srst, srd, txl, rxl, algn, txb, rxb, txd, rxd, fail, mode;
	logic [31:0] seed = 32'he11e;
	logic [2:0] exp_q[$];
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	always #4 mclk_i = ~mclk_i;
	ttc_top uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .restart_i(restart), .mode_switch_i(mswitch),
		.simplex_aligned_i(simplex), .stats_snapshot_tick_i(tick), .serdes_tx_lock_i(lock),
		.serdes_rx_lock_i(lock), .core_rx_aligned_i(lock), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
		.tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_data_i(rx_data), .cfg_wr_o(cfg_wr),
		.cfg_ack_i(cfg_ack), .reconfig_write_complete_o(cmpl), .serdes_reset_o(srst), .stats_rd_o(srd),
		.transmit_serdes_lock_ind_o(txl), .receive_serdes_lock_ind_o(rxl), .rx_aligned_o(algn),
		.tx_busy_o(txb), .rx_busy_o(rxb), .tx_done_o(txd), .rx_done_o(rxd), .rx_data_fail_o(fail),
		.lane_mode_o(mode));
	ttc_mac_model u_mac (.mclk_i(mclk_i), .rstn_i(rstn_i), .link_i(link), .stall_i(stall),
		.corrupt_i(corrupt), .tx_valid_i(tx_valid), .tx_data_i(tx_data), .cfg_wr_i(cfg_wr),
		.tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .cfg_ack_o(cfg_ack),
		.lock_o(lock));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic step(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input logic [2:0] got, input logic [2:0] exp);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait for receive-done level
	task automatic await(input logic v);
		int n;
		n = 0;
		while (rxd !== v && n < 3000)
		begin
			step(1);
			n++;
		end
		chk({2'h0, rxd}, {2'h0, v});
	endtask
	task automatic rerun(input logic [2:0] e);
		chk({txb, rxb, 1'b0}, 3'h0);
		exp_q.push_back(e);
		restart = 1'b1;
		step(2);
		restart = 1'b0;
		await(1'b0);
		await(1'b1);
	endtask
	// Random stalls and timeout; stalls kept off the sampling edge
	always @(posedge mclk_i)
	begin
		#1;
		seed = xs(seed);
		stall = hold | (seed[1:0] == 2'h0);
		simplex = seed[5];
		cyc++;
		if (cyc == 40000)
		begin
			failures++;
			print_verdict();
		end
	end
	// Compare each finished run against the oldest note
	always @(posedge mclk_i)
	begin
		rxd_q <= rxd;
		if (rstn_i && rxd === 1'b1 && rxd_q === 1'b0)
			chk({txd, fail, mode}, exp_q.pop_front());
	end
	initial
	begin
		step(12);
		rstn_i = 1'b1;
		step(40);
		chk({txb, rxb, txd}, 3'h6);
		// Stream stalled so the FIFO fills before draining
		hold = 1'b1;
		exp_q.push_back(3'h4);
		link = 1'b1;
		step(60);
		hold = 1'b0;
		await(1'b1);
		tick = 1'b1;
		step(1);
		tick = 1'b0;
		corrupt = 1'b1;
		rerun(3'h6);
		corrupt = 1'b0;
		rerun(3'h4);
		// One pulse, next only after receive done falls and rises again
		for (int i = 1; i < 3; i++)
		begin
			exp_q.push_back({2'h2, i[0]});
			mswitch = 1'b1;
			step(1);
			mswitch = 1'b0;
			await(1'b0);
			await(1'b1);
		end
		// Let the watcher take the last note before reset
		step(1);
		rstn_i = 1'b0;
		step(2);
		chk({txb, rxd, mode}, 3'h0);
		exp_q.push_back(3'h4);
		rstn_i = 1'b1;
		await(1'b1);
		step(5);
		chk({2'h0, exp_q.size() == 0}, 3'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
